/* File: hw/sac_ctrl.sv */
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sac_cfg.svh"
//
// Contract
// RULE_01 - Four selectable conversion clock sources
// RULE_02 - Alternate clock is the external reference
// RULE_03 - Conversion clock is source divided by setting
// RULE_04 - Alternate clock keeps working in wait
// RULE_05 - Alternate clock unusable in stop modes
// RULE_06 - Counter overflow starts conversion when enabled
// RULE_07 - Trigger independent of counter interrupt enable
// RULE_08 - Triggers accepted in run, wait, stop3
// RULE_09 - Counter clocked by chosen source, prescale, modulo
// RULE_10 - Linear successive approximation, ten bits
// RULE_11 - Unsigned right-justified result, ten or eight
// RULE_12 - Single or continuous; single returns idle
// RULE_13 - Compare less-than or greater-equal, interrupts
// RULE_14 - Completion flag with interrupt request
// RULE_15 - Channel select; 26 temperature, 27 bandgap
// RULE_16 - Sample time and speed/power configurable
// RULE_17 - Conversions continue in wait and stop3
// RULE_18 - Software sequence for temperature reading
// RULE_19 - Control write aborts and restarts conversion
// RULE_20 - All-ones channel powers down, ends continuous
// RULE_21 - Flag sets on finish/compare, clears write/read
// RULE_22 - Trigger select: software or hardware input
// RULE_23 - Async trigger and clocks synchronised first
module sac_ctrl
   import sac_pkg::*;
#(
   parameter int RES_W = 10
) (
   input wire logic sys_clk, // Bus clock
   input wire logic rst, // Synchronous reset, high
   input wire logic [2:0] reg_addr, // Register offset
   input wire logic [7:0] reg_wdata, // Write data
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   output logic [7:0] reg_rdata, // Read data, cycle after strobe
   input wire logic external_reference_clock, // Alternate clock
   input wire logic local_async_osc, // Local oscillator output
   input wire logic hw_trigger_input, // Counter overflow pulse
   input wire logic wait_mode, // MCU in wait
   input wire logic stop3_mode, // MCU in stop3
   input wire logic stop2_mode, // MCU in stop2
   input wire logic comp_in, // Analog comparator decision
   output logic [RES_W-1:0] dac_code, // Trial code
   output logic sample_en, // Sample switch
   output logic [4:0] mux_select, // Analog channel mux
   output logic converter_on, // Analog power
   output logic low_power_mode, // Slow, low current bias
   output logic temp_sensor_en, // Temperature sensor selected
   output logic bandgap_en, // Bandgap selected
   output logic conv_irq // Completion interrupt request
);
   // Result must fit two register bytes
   initial begin
      if (RES_W < 9 || RES_W > 16) $error("sac_ctrl: RES_W must be 9..16");
   end

   // Software visible state
   sac_sc1_t sc1_q; // Enable, continuous, channel
   sac_sc2_t sc2_q; // Trigger and compare setup
   sac_cfg_t cfg_q; // Clock, sample, mode
   logic done_q; // Completion flag
   logic [RES_W-1:0] res_q; // Formatted result
   logic [RES_W-1:0] cv_q; // Compare value
   logic [7:0] rdata_q; // Read data register

   // Sequencer
   sac_state_t st_q; // Current state
   sac_state_t st_d; // Next state

   // Synchronisers for the three asynchronous inputs
   // Bit 0 alternate, 1 local, 2 trigger
   logic [2:0] sync1_q; // First stage, read only by second
   logic [2:0] sync2_q; // Second stage
   logic [2:0] sync3_q; // Delayed copy for edges

   // Conversion clock generation
   logic half_q; // Bus clock halved
   logic [2:0] div_cnt_q; // Divider count

   // Engine handshake
   logic sar_done; // Conversion finished
   logic [RES_W-1:0] sar_res; // Raw result

   // Address decode
   wire wr_sc1 = reg_wr && (reg_addr == `SAC_OFS_SC1);
   wire wr_sc2 = reg_wr && (reg_addr == `SAC_OFS_SC2);
   wire wr_cvh = reg_wr && (reg_addr == `SAC_OFS_CVH);
   wire wr_cvl = reg_wr && (reg_addr == `SAC_OFS_CVL);
   wire wr_cfg = reg_wr && (reg_addr == `SAC_OFS_CFG);

   // This read also clears the flag
   wire rd_resl = reg_rd && (reg_addr == `SAC_OFS_RESL);

   // Channel field of a write, checked for the power-down code
   // All ones turns the analog part off
   wire [4:0] new_ch = reg_wdata[4:0];
   wire new_off = (new_ch == `SAC_CH_OFF);
   wire ch_off = (sc1_q.channel_select == `SAC_CH_OFF);

   // Each bit goes through two flip-flops; edges use stages two and three
   wire [2:0] async_in = {hw_trigger_input, local_async_osc,
                          external_reference_clock};
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_sync
         always_ff @(posedge sys_clk) begin
            if (rst) begin
               sync1_q[gi] <= 1'b0;
               sync2_q[gi] <= 1'b0;
               sync3_q[gi] <= 1'b0;
            end else begin
               sync1_q[gi] <= async_in[gi]; // RULE_23
               sync2_q[gi] <= sync1_q[gi];
               sync3_q[gi] <= sync2_q[gi];
            end
         end
      end
   endgenerate

   // Rising edges seen in the bus clock domain
   // Pulses must outlast two bus cycles
   wire [2:0] rise = sync2_q & ~sync3_q;

   // The alternate clock is the external reference; dead in stop modes
   // Wait excludes stop, so a wait flag keeps it running
   wire in_stop = (stop2_mode || stop3_mode) && !wait_mode; // RULE_04
   wire alt_ok = !in_stop; // RULE_05
   wire alt_tick = rise[0] && alt_ok; // RULE_02

   // The local oscillator runs in every mode
   wire local_tick = rise[1];

   // Pick one of the four sources; each yields one-cycle ticks
   // Bus ticks every cycle, bus/2 every other
   wire src_tick =
      (cfg_q.clk_src == `SAC_SRC_BUS) ? 1'b1 :
      (cfg_q.clk_src == `SAC_SRC_BUS2) ? half_q :
      (cfg_q.clk_src == `SAC_SRC_ALT) ? alt_tick :
      local_tick; // RULE_01

   // Divide by 1, 2, 4 or 8; range checking is software's job
   wire [2:0] div_max =
      (cfg_q.clock_divide_select == 2'h0) ? 3'h0 :
      (cfg_q.clock_divide_select == 2'h1) ? 3'h1 :
      (cfg_q.clock_divide_select == 2'h2) ? 3'h3 : 3'h7;
   wire div_wrap = (div_cnt_q == div_max);
   wire conv_tick = src_tick && div_wrap; // RULE_03

   // Bus/2 toggle runs every cycle, the divider on every source tick
   // Free running, so writes never shift the phase
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         half_q <= 1'b0;
         div_cnt_q <= 3'h0;
      end else begin
         half_q <= ~half_q;
         if (src_tick) begin
            div_cnt_q <= div_wrap ? 3'h0 : div_cnt_q + 3'h1; // RULE_03
         end
      end
   end

   // Counter overflow is taken as is; its own interrupt enable
   // never reaches this block. Stop2 shuts the counter path.
   wire trig_evt = rise[2] && sc2_q.trigger_select; // RULE_06 RULE_07
   // Run, wait and stop3 take triggers; stop2 does not
   wire mode_ok = !stop2_mode; // RULE_08 RULE_17

   // Sequencer next state
   // A control write overrides the rest
   always_comb begin
      st_d = st_q;
      if (wr_sc1) begin
         if (new_off) begin
            st_d = SAC_ST_IDLE; // RULE_20
         end else if (sc2_q.trigger_select) begin
            st_d = SAC_ST_ARMED; // RULE_22
         end else begin
            st_d = SAC_ST_CONV; // RULE_19
         end
      end else begin
         case (st_q)
            SAC_ST_IDLE: begin
               st_d = SAC_ST_IDLE;
            end
            SAC_ST_ARMED: begin
               // Waiting for the next overflow
               if (trig_evt && mode_ok) begin
                  st_d = SAC_ST_CONV; // RULE_06
               end
            end
            SAC_ST_CONV: begin
               // Triggers during a conversion are ignored
               if (sar_done) begin
                  if (sc1_q.continuous_enable) begin
                     st_d = SAC_ST_CONV; // RULE_12
                  end else if (sc2_q.trigger_select) begin
                     st_d = SAC_ST_ARMED;
                  end else begin
                     st_d = SAC_ST_IDLE; // RULE_12
                  end
               end
            end
            default: begin
               st_d = SAC_ST_IDLE;
            end
         endcase
      end
   end

   // A fresh conversion starts on a write, a trigger or a restart
   // Merely staying in conversion starts nothing; a write or a finish must come with it
   wire go = (st_d == SAC_ST_CONV) &&
             (wr_sc1 || (st_q == SAC_ST_ARMED) || sar_done); // RULE_19

   // Any write to the first control register kills what the engine is doing
   wire abort = wr_sc1; // RULE_19

   // State register
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_q <= SAC_ST_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   // Engine
   // Start beats abort inside it
   sac_sar #(
      .RES_W(RES_W)
   ) u_sar (
      .sys_clk(sys_clk),
      .rst(rst),
      .tick(conv_tick),
      .start(go),
      .abort(abort),
      .long_sample(cfg_q.long_sample),
      .comp_in(comp_in),
      .dac_code(dac_code),
      .sampling(sample_en),
      .done(sar_done),
      .result(sar_res)
   );

   // Eight-bit mode keeps the top bits and right-justifies them
   wire mode8 = (cfg_q.mode == `SAC_MODE_8);
   wire [RES_W-1:0] fmt = mode8 ?
      RES_W'(sar_res[RES_W-1:RES_W-8]) : sar_res; // RULE_11

   // 8-bit compares use the low byte only
   wire [RES_W-1:0] cmp_val = mode8 ? RES_W'(cv_q[7:0]) : cv_q;

   // Compare sense: greater-or-equal, or less-than
   wire cmp_true = sc2_q.cmp_ge ? (fmt >= cmp_val)
                                : (fmt < cmp_val); // RULE_13

   // With compare on, only a hit counts as completion
   wire keep = !sc2_q.compare_function_enable || cmp_true; // RULE_21
   wire flag_set = sar_done && keep; // RULE_21
   wire flag_clr = wr_sc1 || rd_resl; // RULE_21

   // Flag and result; a set in the clearing cycle wins
   // The result moves only with the flag
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         done_q <= 1'b0;
         res_q <= '0;
      end else begin
         done_q <= flag_set || (done_q && !flag_clr); // RULE_21 RULE_14
         if (flag_set) begin
            res_q <= fmt; // RULE_11
         end
      end
   end

   // Register writes
   // Read-only bits are never stored
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sc1_q <= `SAC_SC1_RST;
         sc2_q <= `SAC_SC2_RST;
         cfg_q <= `SAC_CFG_RST;
         cv_q <= '0;
      end else begin
         if (wr_sc1) begin
            sc1_q <= reg_wdata[6:0]; // RULE_15
         end
         if (wr_sc2) begin
            sc2_q <= reg_wdata[6:`SAC_SC2_FLD_LSB]; // RULE_22
         end
         if (wr_cfg) begin
            cfg_q <= reg_wdata; // RULE_16
         end
         if (wr_cvh) begin
            cv_q[RES_W-1:8] <= reg_wdata[RES_W-9:0]; // RULE_13
         end
         if (wr_cvl) begin
            cv_q[7:0] <= reg_wdata; // RULE_13
         end
      end
   end

   // Read multiplexer; unmapped offsets read zero
   // Reads have no side effects here except the low result byte, whose read clears the flag
   wire active = (st_q == SAC_ST_CONV);
   wire [7:0] rd_mux =
      (reg_addr == `SAC_OFS_SC1) ? {done_q, sc1_q} :
      (reg_addr == `SAC_OFS_SC2) ? {active, sc2_q, 4'h0} :
      (reg_addr == `SAC_OFS_RESH) ? 8'(res_q[RES_W-1:8]) :
      (reg_addr == `SAC_OFS_RESL) ? res_q[7:0] :
      (reg_addr == `SAC_OFS_CVH) ? 8'(cv_q[RES_W-1:8]) :
      (reg_addr == `SAC_OFS_CVL) ? cv_q[7:0] :
      (reg_addr == `SAC_OFS_CFG) ? cfg_q : 8'h00;

   // Data stand for exactly one cycle after the strobe
   // Zero between reads
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= reg_rd ? rd_mux : 8'h00;
      end
   end

   assign reg_rdata = rdata_q;

   // Analog side controls
   // Plain decodes of the stored channel and configuration
   assign mux_select = sc1_q.channel_select; // RULE_15
   assign converter_on = !ch_off; // RULE_20
   assign low_power_mode = cfg_q.low_power; // RULE_16
   assign temp_sensor_en = (sc1_q.channel_select == `SAC_CH_TEMP); // RULE_15
   assign bandgap_en = (sc1_q.channel_select == `SAC_CH_BGAP); // RULE_15

   // Level request while flag and enable are both high
   assign conv_irq = done_q && sc1_q.int_en; // RULE_14 RULE_13
endmodule
`default_nettype wire

/* File: hw/sac_cfg.svh */
`ifndef SAC_CFG_SVH
`define SAC_CFG_SVH
// Register offsets on the plain register port
`define SAC_OFS_SC1 3'h0
`define SAC_OFS_SC2 3'h1
`define SAC_OFS_RESH 3'h2
`define SAC_OFS_RESL 3'h3
`define SAC_OFS_CVH 3'h4
`define SAC_OFS_CVL 3'h5
`define SAC_OFS_CFG 3'h6
// Field positions
`define SAC_SC1_FLAG_BIT 7
`define SAC_SC2_FLD_LSB 4
// Reset values; the converter wakes up switched off
`define SAC_SC1_RST 7'h1F
`define SAC_SC2_RST 3'h0
`define SAC_CFG_RST 8'h00
// Channel codes with a special meaning
`define SAC_CH_OFF 5'h1F
`define SAC_CH_TEMP 5'h1A
`define SAC_CH_BGAP 5'h1B
// Clock source codes
`define SAC_SRC_BUS 2'h0
`define SAC_SRC_BUS2 2'h1
`define SAC_SRC_ALT 2'h2
`define SAC_SRC_LOCAL 2'h3
// Result mode codes
`define SAC_MODE_8 2'h0
`define SAC_MODE_10 2'h2
// Sample phase length in conversion clock ticks, minus one
`define SAC_SMP_SHORT 5'h03
`define SAC_SMP_LONG 5'h17
`endif

/* File: hw/sac_pkg.sv */
package sac_pkg;
   // Sequencer states, one-hot
   typedef enum logic [2:0] {
      SAC_ST_IDLE = 3'b001,
      SAC_ST_ARMED = 3'b010,
      SAC_ST_CONV = 3'b100
   } sac_state_t;
   // First control register without its flag
   typedef struct packed {
      logic int_en;
      logic continuous_enable;
      logic [4:0] channel_select;
   } sac_sc1_t;
   // Second control register writable fields
   typedef struct packed {
      logic trigger_select;
      logic compare_function_enable;
      logic cmp_ge;
   } sac_sc2_t;
   // Configuration register
   typedef struct packed {
      logic low_power;
      logic [1:0] clock_divide_select;
      logic long_sample;
      logic [1:0] mode;
      logic [1:0] clk_src;
   } sac_cfg_t;
endpackage

/* File: hw/sac_sar.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sac_cfg.svh"
// Successive-approximation engine: sample phase, then one bit per tick
module sac_sar #(
   parameter int RES_W = 10
) (
   input wire logic sys_clk, // Bus clock
   input wire logic rst, // Synchronous reset
   input wire logic tick, // Conversion clock tick
   input wire logic start, // Begin a conversion
   input wire logic abort, // Drop the conversion in progress
   input wire logic long_sample, // Long sample phase
   input wire logic comp_in, // Analog input at or above trial code
   output logic [RES_W-1:0] dac_code, // Trial code to the analog side
   output logic sampling, // Sample switch closed
   output logic done, // One-cycle end of conversion
   output logic [RES_W-1:0] result // Raw result, valid with done
);
   initial begin
      if (RES_W < 9 || RES_W > 16) $error("sac_sar: RES_W must be 9..16");
   end
   logic busy_q; // Conversion running
   logic samp_q; // In sample phase
   logic [4:0] smp_q; // Sample ticks left
   logic [3:0] idx_q; // Bit under trial
   logic [RES_W-1:0] dac_q; // Trial register
   logic done_q; // End pulse
   logic [RES_W-1:0] res_q; // Captured result
   // Trial bit mask and the decision for it
   wire [RES_W-1:0] bit_m = RES_W'(1) << idx_q;
   wire [RES_W-1:0] kept = comp_in ? dac_q : (dac_q & ~bit_m); // RULE_10
   wire [RES_W-1:0] nxt_m = bit_m >> 1;
   wire [4:0] smp_len = long_sample ? `SAC_SMP_LONG : `SAC_SMP_SHORT; // RULE_16
   // Start wins over abort so that a rewrite restarts at once
   always_ff @(posedge sys_clk) begin
      done_q <= 1'b0;
      if (rst) begin
         busy_q <= 1'b0;
         samp_q <= 1'b0;
         smp_q <= 5'h00;
         idx_q <= 4'h0;
         dac_q <= '0;
         res_q <= '0;
      end else if (start) begin
         busy_q <= 1'b1;
         samp_q <= 1'b1;
         smp_q <= smp_len;
         dac_q <= '0;
      end else if (abort) begin
         busy_q <= 1'b0;
         samp_q <= 1'b0;
         dac_q <= '0;
      end else if (busy_q && tick && samp_q) begin
         smp_q <= smp_q - 5'h01;
         if (smp_q == 5'h00) begin
            samp_q <= 1'b0;
            idx_q <= 4'(RES_W - 1);
            dac_q <= {1'b1, {(RES_W-1){1'b0}}};
         end
      end else if (busy_q && tick) begin
         dac_q <= kept | nxt_m; // RULE_10
         idx_q <= idx_q - 4'h1;
         if (idx_q == 4'h0) begin
            res_q <= kept;
            done_q <= 1'b1;
            busy_q <= 1'b0;
         end
      end
   end
   assign dac_code = dac_q;
   assign sampling = samp_q;
   assign done = done_q;
   assign result = res_q;
endmodule
`default_nettype wire

/* File: test/sac_ctrl_chk.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sac_cfg.svh"
// Port-level checker for the converter control block
module sac_ctrl_chk #(
   parameter int RES_W = 10
) (
   input wire logic sys_clk, // Bus clock
   input wire logic rst, // Synchronous reset
   input wire logic [2:0] reg_addr, // Register offset
   input wire logic [7:0] reg_wdata, // Write data
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   input wire logic [7:0] reg_rdata, // Read data
   input wire logic external_reference_clock, // Alternate clock
   input wire logic local_async_osc, // Local oscillator
   input wire logic hw_trigger_input, // Overflow pulse
   input wire logic wait_mode, // Wait
   input wire logic stop3_mode, // Stop3
   input wire logic stop2_mode, // Stop2
   input wire logic comp_in, // Comparator
   input wire logic [RES_W-1:0] dac_code, // Trial code
   input wire logic sample_en, // Sample switch
   input wire logic [4:0] mux_select, // Channel mux
   input wire logic converter_on, // Analog power
   input wire logic low_power_mode, // Low power bias
   input wire logic temp_sensor_en, // Temperature sensor
   input wire logic bandgap_en, // Bandgap
   input wire logic conv_irq // Interrupt request
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Write to the first control register
   wire logic sc1_wr = reg_wr && (reg_addr == `SAC_OFS_SC1);
   AST_POWER: assert property (converter_on == (mux_select != `SAC_CH_OFF))
      else $error("analog power disagrees with channel");
   AST_TEMP_SEL: assert property (temp_sensor_en == (mux_select == `SAC_CH_TEMP))
      else $error("temperature select wrong");
   AST_BGAP_SEL: assert property (bandgap_en == (mux_select == `SAC_CH_BGAP))
      else $error("bandgap select wrong");
   AST_CH_WRITE: assert property (sc1_wr |=> mux_select == 5'($past(reg_wdata)))
      else $error("channel not taken from write");
   // Switching off must leave no sampling behind, also in continuous mode
   AST_OFF_QUIET: assert property (sc1_wr && reg_wdata[4:0] == `SAC_CH_OFF
      |=> ##1 (!sample_en && !converter_on) [*8]) else $error("activity after switch off");
   AST_IRQ_MASK: assert property (sc1_wr && !reg_wdata[6] |=> !conv_irq)
      else $error("interrupt while disabled");
   AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside read slot");
   AST_UNMAPPED: assert property ($past(reg_rd) && $past(reg_addr) == 3'h7 |-> reg_rdata == 8'h00)
      else $error("unmapped offset not zero");
   AST_SC1_READ: assert property ($past(reg_rd) && $past(reg_addr) == `SAC_OFS_SC1
      |-> reg_rdata[4:0] == mux_select) else $error("channel readback wrong");
   cover property (sc1_wr ##1 sample_en);
   cover property ($rose(conv_irq));
   cover property ($rose(hw_trigger_input) ##[1:20] sample_en);
endmodule
bind sac_ctrl sac_ctrl_chk #(.RES_W(RES_W)) sac_ctrl_chk_i (.sys_clk(sys_clk), .rst(rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .external_reference_clock(external_reference_clock),
   .local_async_osc(local_async_osc), .hw_trigger_input(hw_trigger_input),
   .wait_mode(wait_mode), .stop3_mode(stop3_mode), .stop2_mode(stop2_mode), .comp_in(comp_in),
   .dac_code(dac_code), .sample_en(sample_en), .mux_select(mux_select),
   .converter_on(converter_on), .low_power_mode(low_power_mode),
   .temp_sensor_en(temp_sensor_en), .bandgap_en(bandgap_en), .conv_irq(conv_irq));
`default_nettype wire

/* File: test/sac_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Analog comparator and periodic trigger counter seen from the block
module sac_far_model #(
   parameter int PRESCALE = 4,
   parameter int MODULO = 50
) (
   input wire logic sys_clk, // Bus clock
   input wire logic rst, // Synchronous reset
   input wire logic run, // Counter enabled
   input wire logic counter_interrupt_enable, // Counter interrupt, no say over trigger
   input wire logic [9:0] level, // Analog input as a code
   input wire logic [9:0] dac_code, // Trial code
   input wire logic converter_on, // Analog power
   output logic comp_in, // Comparator decision
   output logic hw_trigger_input // Overflow pulse
);
   logic [7:0] pre_q; // Prescale count
   logic [7:0] cnt_q; // Modulo count
   logic [1:0] pw_q; // Pulse width left
   logic tog_q = 1'b0; // Garbage source while unpowered
   // Powered down, the comparator output means nothing, so it toggles
   assign comp_in = converter_on ? (level >= dac_code) : tog_q;
   assign hw_trigger_input = (pw_q != 2'h0);
   // Prescale then modulo; overflow pulse three cycles wide for the synchroniser
   always @(posedge sys_clk) begin
      tog_q <= ~tog_q;
      if (rst || !run) begin
         pre_q <= 8'h00;
         cnt_q <= 8'h00;
         pw_q <= 2'h0;
      end else if (pre_q == 8'(PRESCALE - 1)) begin
         pre_q <= 8'h00;
         cnt_q <= (cnt_q == 8'(MODULO - 1)) ? 8'h00 : cnt_q + 8'h01;
         pw_q <= (cnt_q == 8'(MODULO - 1)) ? 2'h3 : (pw_q == 2'h0 ? 2'h0 : pw_q - 2'h1);
      end else begin
         pre_q <= pre_q + 8'h01;
         pw_q <= (pw_q == 2'h0) ? 2'h0 : pw_q - 2'h1;
      end
   end
endmodule
`default_nettype wire

/* File: test/test_sac_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sac_cfg.svh"
module test_sac_ctrl;
   logic sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0; // Clock, reset, strobes
   logic [2:0] reg_addr = 3'h0; // Offset
   logic [7:0] reg_wdata = 8'h00; // Write data
   logic ext_clk = 1'b0, osc = 1'b0, run = 1'b0; // Alternate clock, oscillator, counter
   logic wait_m = 1'b0, stop3_m = 1'b0, stop2_m = 1'b0; // Power modes
   logic [9:0] level = 10'h000; // Analog level
   wire logic [7:0] reg_rdata; // Read data
   wire logic [9:0] dac_code; // Trial code
   wire logic [4:0] mux_select; // Channel
   wire logic comp_in, hw_trig, sample_en, converter_on, low_power_mode; // Analog side
   wire logic temp_sensor_en, bandgap_en, conv_irq; // Selects, interrupt
   int mismatches = 0, n_tests = 0; // Counters
   always #5 sys_clk = ~sys_clk;
   always #20 ext_clk = ~ext_clk;
   always #30 osc = ~osc;
   sac_ctrl #(.RES_W(10)) sac_ctrl_i (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .external_reference_clock(ext_clk), .local_async_osc(osc), .hw_trigger_input(hw_trig),
      .wait_mode(wait_m), .stop3_mode(stop3_m), .stop2_mode(stop2_m), .comp_in(comp_in),
      .dac_code(dac_code), .sample_en(sample_en), .mux_select(mux_select),
      .converter_on(converter_on), .low_power_mode(low_power_mode),
      .temp_sensor_en(temp_sensor_en), .bandgap_en(bandgap_en), .conv_irq(conv_irq));
   // Counter overflows with its own interrupt held off
   sac_far_model #(.PRESCALE(4), .MODULO(50)) sac_far_model_i (.sys_clk(sys_clk), .rst(rst),
      .run(run), .counter_interrupt_enable(1'b0), .level(level), .dac_code(dac_code),
      .converter_on(converter_on), .comp_in(comp_in), .hw_trigger_input(hw_trig));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge sys_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge sys_clk) reg_wr <= 1'b0;
   endtask
   // Data stands only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge sys_clk) {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge sys_clk) reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // Poll the flag by reads of the first control register, bounded
   task automatic wflag(input int n, output logic f);
      logic [7:0] v;
      f = 1'b0;
      for (int i = 0; i < n && !f; i++) begin
         rd(`SAC_OFS_SC1, v);
         f = v[7];
      end
   endtask
   // One started conversion with result and flag checks
   task automatic conv(input logic [7:0] sc1, input logic [9:0] lv, input logic ten);
      logic f;
      logic [7:0] v;
      @(posedge sys_clk) level <= lv;
      wr(`SAC_OFS_SC1, sc1);
      wflag(1500, f);
      chk({7'h0, f}, 8'h01);
      chk({7'h0, conv_irq}, {7'h0, sc1[6]});
      rd(`SAC_OFS_RESH, v);
      if (ten) chk(v, {6'h0, lv[9:8]});
      rd(`SAC_OFS_RESL, v);
      chk(v, ten ? lv[7:0] : lv[9:2]);
      rd(`SAC_OFS_SC1, v);
      chk({v[7], 6'h0, conv_irq}, 8'h00);
   endtask
   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge sys_clk);
      mismatches++;
      end_sim();
   end
   initial begin
      logic [7:0] v;
      logic f;
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      rd(`SAC_OFS_SC1, v);
      chk({v[7:0]}, 8'h1F);
      rd(3'h7, v);
      chk(v, 8'h00);
      // All four sources, divided by 1, 2, 4 and 8 in turn, ten-bit results, interrupt enabled
      for (int s = 0; s < 4; s++) begin
         wr(`SAC_OFS_CFG, 8'h08 | 8'(s * 33));
         conv(8'h45, 10'h2A5 ^ 10'(s * 3), 1'b1);
      end
      wr(`SAC_OFS_CFG, 8'h90);
      conv(8'h03, 10'h3C7, 1'b0);
      chk({7'h0, low_power_mode}, 8'h01);
      // Bandgap then temperature, long sample
      wr(`SAC_OFS_CFG, 8'h18);
      conv(8'h1B, 10'h1E0, 1'b1);
      chk({6'h0, bandgap_en, temp_sensor_en}, 8'h02);
      conv(8'h1A, 10'h0A3, 1'b1);
      chk({6'h0, bandgap_en, temp_sensor_en}, 8'h01);
      // Local oscillator divided by eight takes about 670 cycles
      wr(`SAC_OFS_CFG, 8'h6B);
      wr(`SAC_OFS_SC1, 8'h07);
      wflag(100, f);
      chk({7'h0, f}, 8'h00);
      wflag(1000, f);
      chk({7'h0, f}, 8'h01);
      // Alternate clock frozen in stop2, alive in wait
      wr(`SAC_OFS_CFG, 8'h0A);
      @(posedge sys_clk) stop2_m <= 1'b1;
      wr(`SAC_OFS_SC1, 8'h05);
      wflag(100, f);
      chk({7'h0, f}, 8'h00);
      @(posedge sys_clk) {stop2_m, wait_m} <= 2'b01;
      wflag(200, f);
      chk({7'h0, f}, 8'h01);
      @(posedge sys_clk) wait_m <= 1'b0;
      // Abort mid-conversion; new channel and level win
      wr(`SAC_OFS_CFG, 8'h08);
      wr(`SAC_OFS_SC1, 8'h05);
      rd(`SAC_OFS_SC2, v);
      chk({v[7], 7'h0}, 8'h80);
      conv(8'h06, 10'h0F0, 1'b1);
      rd(`SAC_OFS_SC2, v);
      chk({v[7], 7'h0}, 8'h00);
      // Compare: equal passes greater-or-equal; not-less gives no flag, no update
      wr(`SAC_OFS_CVH, 8'h01);
      wr(`SAC_OFS_CVL, 8'h55);
      wr(`SAC_OFS_SC2, 8'h30);
      conv(8'h05, 10'h155, 1'b1);
      wr(`SAC_OFS_SC2, 8'h20);
      @(posedge sys_clk) level <= 10'h156;
      wr(`SAC_OFS_SC1, 8'h05);
      wflag(60, f);
      chk({7'h0, f}, 8'h00);
      rd(`SAC_OFS_RESL, v);
      chk(v, 8'h55);
      wr(`SAC_OFS_SC2, 8'h00);
      // Continuous, then switched off with no extra conversion
      wr(`SAC_OFS_SC1, 8'h25);
      wflag(50, f);
      rd(`SAC_OFS_RESL, v);
      wflag(50, f);
      chk({7'h0, f}, 8'h01);
      rd(`SAC_OFS_RESL, v);
      wr(`SAC_OFS_SC1, 8'h3F);
      repeat (40) @(posedge sys_clk);
      rd(`SAC_OFS_SC1, v);
      chk(v, 8'h3F);
      // Hardware trigger in stop3: armed, then each overflow converts
      wr(`SAC_OFS_SC2, 8'h40);
      wr(`SAC_OFS_SC1, 8'h05);
      wflag(30, f);
      chk({7'h0, f}, 8'h00);
      @(posedge sys_clk) {stop3_m, run} <= 2'b11;
      wflag(300, f);
      chk({7'h0, f}, 8'h01);
      rd(`SAC_OFS_RESL, v);
      chk(v, 8'h56);
      wflag(300, f);
      chk({7'h0, f}, 8'h01);
      end_sim();
   end
endmodule
`default_nettype wire
